// >>> hdl/grs_remote_status.sv
// Top: remote/local, talker/listener, bus commands and status byte
module grs_remote_status
   import grs_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              nrst,
   // Bus side
   input  wire logic [7:0]        cmdByte,
   input  wire logic              cmdValid,
   input  wire logic              atnPin,
   input  wire logic              renPin,
   input  wire logic              ifcPin,
   input  wire logic              spollRead,
   input  wire logic [ADDR_W-1:0] myAddr,
   // Front panel
   input  wire logic              localKeyPin,
   input  wire logic [NKEY-1:0]   keyPins,
   output      logic [NKEY-1:0]   keysOut,
   output      logic              remoteIndicator,
   output      logic              listenerIndicator,
   output      logic              talkerIndicator,
   output      logic              srqIndicator,
   output      logic              lockoutActive,
   // Instrument core
   input  wire logic [2:0]        trigSrcBus,
   output      logic [2:0]        trigPulse,
   output      logic              devClearPulse,
   input  wire logic              mavIn,
   input  wire logic              eavIn,
   // Status structure
   input  wire logic [SET_W-1:0]  stdCond,
   input  wire logic [SET_W-1:0]  operCond,
   input  wire logic [SET_W-1:0]  quesCond,
   input  wire logic [SET_W-1:0]  measCond,
   input  wire logic [2:0]        rdSel,
   input  wire logic              rdEvt,
   input  wire logic              rdEn,
   output      logic [SET_W-1:0]  rdData,
   input  wire logic [2:0]        wrSel,
   input  wire logic              wrEn,
   input  wire logic [SET_W-1:0]  wrData,
   input  wire logic              clsCmd,
   input  wire logic              presetCmd,
   output      logic [7:0]        statusByte,
   output      logic [7:0]        spollByte,
   output      logic              spollMode,
   output      logic              srqOut
);
   // Remote states in one place, used for indicator and key gating
   function automatic logic isRemote(input grs_rl_t s);
      isRemote = (s == ST_REMS) || (s == ST_RWLS);
   endfunction : isRemote

   // Two-stage synchronisers for pins; stage one feeds only stage two
   logic [2:0]      pinMeta_reg;    // ATN, REN, IFC first stage
   logic [2:0]      pinSync_reg;    // Second stage
   logic [NKEY:0]   keyMeta_reg;    // Keys plus local key first stage
   logic [NKEY:0]   keySync_reg;    // Second stage
   logic            localPrev_reg;  // For press detection
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         pinMeta_reg   <= 3'h0;
         pinSync_reg   <= 3'h0;
         keyMeta_reg   <= '0;
         keySync_reg   <= '0;
         localPrev_reg <= 1'b0;
      end else begin
         pinMeta_reg   <= {ifcPin, renPin, atnPin};
         pinSync_reg   <= pinMeta_reg;
         keyMeta_reg   <= {localKeyPin, keyPins};
         keySync_reg   <= keyMeta_reg;
         localPrev_reg <= keySync_reg[NKEY];
      end
   end
   logic atnSync;
   logic renSync;
   logic ifcSync;
   logic localPress;
   assign atnSync    = pinSync_reg[0];
   assign renSync    = pinSync_reg[1];
   assign ifcSync    = pinSync_reg[2];
   assign localPress = keySync_reg[NKEY] & ~localPrev_reg;

   // Command decoder
   grs_cmd_if cmd ();
   grs_cmd_decode u_dec (
      .core_clk (core_clk),
      .nrst     (nrst),
      .cmdByte  (cmdByte),
      .cmdValid (cmdValid),
      .atnSync  (atnSync),
      .myAddr   (myAddr),
      .cmd      (cmd.src)
   );

   // Talker and listener state
   logic talk_reg;
   logic listen_reg;
   logic talk_next;
   logic listen_next;
   assign talk_next   = cmd.mta ? 1'b1
                      : (cmd.unt | cmd.mla) ? 1'b0 : talk_reg;
   assign listen_next = cmd.mla ? 1'b1
                      : (cmd.unl | cmd.mta) ? 1'b0 : listen_reg;

   // Remote/local state machine
   grs_rl_t state_reg;
   grs_rl_t state_next;
   logic    gtlHere;
   assign gtlHere = cmd.gtl & listen_reg;   // GTL is addressed
   always_comb begin
      state_next = state_reg;
      if (!renSync) begin
         state_next = ST_LOCS;               // REN false drops remote and lockout
      end else begin
         unique case (state_reg)
            ST_LOCS: begin
               if (cmd.mla) begin
                  state_next = cmd.llo ? ST_RWLS : ST_REMS;
               end else if (cmd.llo) begin
                  state_next = ST_LWLS;
               end
            end
            ST_REMS: begin
               if (gtlHere || localPress) begin
                  state_next = ST_LOCS;
               end else if (cmd.llo) begin
                  state_next = ST_RWLS;
               end
            end
            ST_LWLS: begin
               if (cmd.mla) begin
                  state_next = ST_RWLS;
               end
            end
            ST_RWLS: begin
               // Local key ignored under lockout
               if (gtlHere) begin
                  state_next = ST_LWLS;
               end
            end
            default: state_next = ST_LOCS;
         endcase
      end
   end

   // Interface state registers and indicators
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         state_reg         <= ST_LOCS;
         talk_reg          <= 1'b0;
         listen_reg        <= 1'b0;
         remoteIndicator   <= 1'b0;
         lockoutActive     <= 1'b0;
         talkerIndicator   <= 1'b0;
         listenerIndicator <= 1'b0;
         keysOut           <= '0;
      end else begin
         state_reg         <= state_next;
         talk_reg          <= talk_next & ~ifcSync;
         listen_reg        <= listen_next & ~ifcSync;
         talkerIndicator   <= talk_next & ~ifcSync;
         listenerIndicator <= listen_next & ~ifcSync;
         remoteIndicator   <= isRemote(state_next);
         lockoutActive     <= (state_next == ST_LWLS) || (state_next == ST_RWLS);
         // Keys pass only in local; one cycle behind the indicator
         keysOut           <= isRemote(state_reg) ? '0 : keySync_reg[NKEY-1:0];
      end
   end

   // Device clear and trigger; clear touches no setting or status register
   logic clearHit;
   logic getHit;
   assign clearHit = cmd.dcl | (cmd.sdc & listen_reg);
   assign getHit   = cmd.get & listen_reg;
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         devClearPulse <= 1'b0;
         trigPulse     <= 3'h0;
         spollMode     <= 1'b0;
      end else begin
         devClearPulse <= clearHit;
         trigPulse     <= {3{getHit}} & trigSrcBus;
         spollMode     <= cmd.spe ? 1'b1 : (cmd.spd | ifcSync) ? 1'b0 : spollMode;
      end
   end

   // Four status register sets; standard enable survives preset
   logic [SET_W-1:0] evtV [NSET];
   logic [SET_W-1:0] enV  [NSET];
   logic [SET_W-1:0] condV[NSET];
   logic [NSET-1:0]  sumV;
   assign condV[0] = stdCond;
   assign condV[1] = operCond;
   assign condV[2] = quesCond;
   assign condV[3] = measCond;
   for (genvar i = 0; i < NSET; i++) begin : g_set
      grs_status_set #(
         .W          (SET_W),
         .PRESET_CLR (i != 0)
      ) u_set (
         .core_clk  (core_clk),
         .nrst      (nrst),
         .cond      (condV[i]),
         .wrEn      (wrEn && wrSel == 3'(i)),
         .wrData    (wrData),
         .rdEvt     (rdEvt && rdSel == 3'(i)),
         .clsCmd    (clsCmd),
         .presetCmd (presetCmd),
         .evt       (evtV[i]),
         .en        (enV[i]),
         .summary   (sumV[i])
      );
   end

   // Service request enable, cleared only by power-up or a write
   logic [7:0] sre_reg;
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         sre_reg <= BYTE_RST;
      end else if (wrEn && wrSel == SEL_SRE) begin
         sre_reg <= wrData[7:0];
      end
   end

   // Summary byte without bit 6; bits follow their sources, no latching
   logic [7:0] sumByte;
   logic [7:0] masked;
   logic       masterSum;   // Any enabled summary bit set
   always_comb begin
      sumByte         = BYTE_RST;
      sumByte[SB_MSB] = sumV[SEL_MEAS[1:0]];
      sumByte[SB_EAV] = eavIn;
      sumByte[SB_QSB] = sumV[SEL_QUES[1:0]];
      sumByte[SB_MAV] = mavIn;
      sumByte[SB_STDSUM] = sumV[SEL_STD[1:0]];
      sumByte[SB_OSB] = sumV[SEL_OPER[1:0]];
   end
   assign masked = sumByte & sre_reg;
   assign masterSum = |masked;

   // Request for service: set by an enabled summary rising, cleared by poll
   logic [7:0] maskedPrev_reg;
   logic       rqs_reg;
   logic       rqsSet;
   logic       pollDone;
   assign rqsSet   = |(masked & ~maskedPrev_reg);
   assign pollDone = spollRead & spollMode & talk_reg;
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         maskedPrev_reg <= BYTE_RST;
         rqs_reg        <= 1'b0;
      end else begin
         maskedPrev_reg <= masked;
         // Set wins over the poll clear; vanished causes also clear
         rqs_reg        <= rqsSet | (rqs_reg & ~pollDone & masterSum);
      end
   end

   // Registered status outputs and read-back
   logic [SET_W-1:0] rdMux;
   assign rdMux = (rdSel == SEL_SRE) ? SET_W'(sre_reg)
                : rdEvt ? evtV[rdSel[1:0]]
                : rdEn  ? enV[rdSel[1:0]] : condV[rdSel[1:0]];
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         statusByte   <= BYTE_RST;
         spollByte    <= BYTE_RST;
         srqIndicator <= 1'b0;
         srqOut       <= 1'b0;
         rdData       <= SET_RST;
      end else begin
         statusByte   <= sumByte | (8'(masterSum) << SB_RQS);
         // Poll byte is valid whether or not service is requested
         spollByte    <= sumByte | (8'(rqs_reg) << SB_RQS);
         srqIndicator <= rqs_reg;
         srqOut       <= rqs_reg;
         rdData       <= rdMux;
      end
   end

   // Checks
   property p_gtl_local;
      @(posedge core_clk) disable iff (!nrst)
      (cmd.gtl && listen_reg && isRemote(state_reg) && !localPress) |=> !remoteIndicator;
   endproperty
   a_gtl_local: assert property (p_gtl_local) else $error("GTL left remote on");
   property p_dcl;
      @(posedge core_clk) disable iff (!nrst)
      cmd.dcl |=> devClearPulse;
   endproperty
   a_dcl: assert property (p_dcl) else $error("DCL did not clear");
   property p_sdc_unaddr;
      @(posedge core_clk) disable iff (!nrst)
      (cmd.sdc && !listen_reg && !cmd.dcl) |=> !devClearPulse;
   endproperty
   a_sdc_unaddr: assert property (p_sdc_unaddr) else $error("SDC cleared unaddressed");
   property p_get;
      @(posedge core_clk) disable iff (!nrst)
      (cmd.get && listen_reg) |=> (trigPulse == $past(trigSrcBus));
   endproperty
   a_get: assert property (p_get) else $error("GET trigger wrong");
   property p_ren_alone;
      @(posedge core_clk) disable iff (!nrst)
      (state_reg == ST_LOCS && !cmd.mla) |=> !remoteIndicator;
   endproperty
   a_ren_alone: assert property (p_ren_alone) else $error("Remote without listen address");
   property p_keys_locked;
      @(posedge core_clk) disable iff (!nrst)
      remoteIndicator |=> (keysOut == '0);
   endproperty
   a_keys_locked: assert property (p_keys_locked) else $error("Key passed in remote");
   property p_talk;
      @(posedge core_clk) disable iff (!nrst)
      (cmd.mta && !ifcSync) |=> (talkerIndicator && !listenerIndicator);
   endproperty
   a_talk: assert property (p_talk) else $error("Talk address mishandled");
   property p_ifc;
      @(posedge core_clk) disable iff (!nrst)
      ifcSync |=> (!talkerIndicator && !listenerIndicator);
   endproperty
   a_ifc: assert property (p_ifc) else $error("IFC left talker or listener");
   property p_lockout;
      @(posedge core_clk) disable iff (!nrst)
      (state_reg == ST_RWLS && localPress && renSync && !cmd.gtl) |=> remoteIndicator;
   endproperty
   a_lockout: assert property (p_lockout) else $error("Local key worked under lockout");
   property p_poll_rqs;
      @(posedge core_clk) disable iff (!nrst)
      (pollDone && !rqsSet) |=> ##1 !srqIndicator;
   endproperty
   a_poll_rqs: assert property (p_poll_rqs) else $error("Poll left RQS set");
   c_remote: cover property (@(posedge core_clk) disable iff (!nrst) $rose(remoteIndicator));
   c_clear:  cover property (@(posedge core_clk) disable iff (!nrst) devClearPulse);
   c_trig:   cover property (@(posedge core_clk) disable iff (!nrst) |trigPulse);
   c_srq:    cover property (@(posedge core_clk) disable iff (!nrst) $fell(srqOut) && statusByte[SB_RQS]);
endmodule : grs_remote_status

// >>> hdl/grs_pkg.sv
// Constants and types shared by the remote and status unit
// Operation
// - GTL in remote returns to local, keys live
// - DCL empties buffers, queue, deferred, blocking
// - Device clear keeps settings and stored data
// - DCL acts regardless of addressing
// - SDC clears only when addressed to listen
// - GET triggers layers that select bus trigger
// - Serial poll returns status byte any time
// - Remote needs listen address with remote enable
// - Remote ignores keys except local key
// - Talker active on MTA; idle UNT/MLA/IFC
// - Listener active on MLA; idle UNL/MTA/IFC
// - SRQ indicator holds until poll or cleared
// - Local key cancels remote unless locked out
// - Four status sets feed status byte
// - Condition registers track live conditions
// - Event bits latch on condition rise
// - Event AND enable, ORed to summary
// - Event read, power-up, CLS clear events
// - Enable reads harmless; cleared at power-up
// - Preset clears three enables, not standard
// - Writing zero clears standard event enable
// - Poll clears request bit, master summary stays
package grs_pkg;
   // Widths
   localparam int          SET_W      = 16;         // Bits per status register set
   localparam int          ADDR_W     = 5;          // Primary address width
   localparam int          NKEY       = 8;          // Front-panel keys
   localparam int          NSET       = 4;          // Status register sets
   localparam logic [15:0] SET_RST    = 16'h0000;   // Event/enable reset value
   localparam logic [7:0]  BYTE_RST   = 8'h00;      // Status byte reset value
   // Bus command bytes, ATN true, bit 7 ignored
   localparam logic [6:0]  CMD_GTL    = 7'h01;
   localparam logic [6:0]  CMD_SDC    = 7'h04;
   localparam logic [6:0]  CMD_GET    = 7'h08;
   localparam logic [6:0]  CMD_LLO    = 7'h11;
   localparam logic [6:0]  CMD_DCL    = 7'h14;
   localparam logic [6:0]  CMD_SPE    = 7'h18;
   localparam logic [6:0]  CMD_SPD    = 7'h19;
   localparam logic [6:0]  CMD_UNL    = 7'h3F;
   localparam logic [6:0]  CMD_UNT    = 7'h5F;
   localparam logic [1:0]  GRP_LISTEN = 2'h1;       // Bits 6:5 of a listen address
   localparam logic [1:0]  GRP_TALK   = 2'h2;       // Bits 6:5 of a talk address
   // Set indices on the select ports
   localparam logic [2:0]  SEL_STD    = 3'h0;
   localparam logic [2:0]  SEL_OPER   = 3'h1;
   localparam logic [2:0]  SEL_QUES   = 3'h2;
   localparam logic [2:0]  SEL_MEAS   = 3'h3;
   localparam logic [2:0]  SEL_SRE    = 3'h4;
   // Status byte bit positions
   localparam int          SB_MSB     = 0;
   localparam int          SB_EAV     = 2;
   localparam int          SB_QSB     = 3;
   localparam int          SB_MAV     = 4;
   localparam int          SB_STDSUM  = 5;
   localparam int          SB_RQS     = 6;
   localparam int          SB_OSB     = 7;
   localparam int          OPER_MEAS  = 4;          // Measuring flag in operation set
   // Trigger layer bits
   localparam int          TRG_ARM    = 0;
   localparam int          TRG_SCAN   = 1;
   localparam int          TRG_MEAS   = 2;
   // Remote/local state, one-hot
   typedef enum logic [3:0] {
      ST_LOCS = 4'h1,   // Local
      ST_REMS = 4'h2,   // Remote
      ST_LWLS = 4'h4,   // Local with lockout
      ST_RWLS = 4'h8    // Remote with lockout
   } grs_rl_t;
endpackage : grs_pkg

// >>> hdl/grs_cmd_if.sv
// Decoded bus command pulses from the decoder to the core
interface grs_cmd_if;
   logic mla;   // My listen address
   logic mta;   // My talk address
   logic unl;   // Unlisten
   logic unt;   // Untalk
   logic gtl;   // Go to local
   logic sdc;   // Selective device clear
   logic dcl;   // Device clear
   logic get;   // Group execute trigger
   logic llo;   // Local lockout
   logic spe;   // Serial poll enable
   logic spd;   // Serial poll disable
   modport src (output mla, mta, unl, unt, gtl, sdc, dcl, get, llo, spe, spd);
   modport snk (input  mla, mta, unl, unt, gtl, sdc, dcl, get, llo, spe, spd);
endinterface : grs_cmd_if

// >>> hdl/grs_cmd_decode.sv
// Bus command byte decoder with own-address compare
module grs_cmd_decode
   import grs_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              nrst,
   input  wire logic [7:0]        cmdByte,
   input  wire logic              cmdValid,
   input  wire logic              atnSync,
   input  wire logic [ADDR_W-1:0] myAddr,
   grs_cmd_if.src                 cmd
);
   // Only bytes sent with ATN true are commands
   logic       isCmd;
   logic [6:0] code;
   logic       addrHit;
   assign isCmd   = cmdValid & atnSync;
   assign code    = cmdByte[6:0];
   assign addrHit = (code[ADDR_W-1:0] == myAddr);

   // Address 31 is never a primary address, so the UNL/UNT codes cannot alias it
   logic mlaNext;
   logic mtaNext;
   assign mlaNext = isCmd & (code[6:5] == GRP_LISTEN) & addrHit & (code != CMD_UNL);
   assign mtaNext = isCmd & (code[6:5] == GRP_TALK) & addrHit & (code != CMD_UNT);

   // Registered one-cycle pulses
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         cmd.mla <= 1'b0;
         cmd.mta <= 1'b0;
         cmd.unl <= 1'b0;
         cmd.unt <= 1'b0;
         cmd.gtl <= 1'b0;
         cmd.sdc <= 1'b0;
         cmd.dcl <= 1'b0;
         cmd.get <= 1'b0;
         cmd.llo <= 1'b0;
         cmd.spe <= 1'b0;
         cmd.spd <= 1'b0;
      end else begin
         cmd.mla <= mlaNext;
         cmd.mta <= mtaNext;
         cmd.unl <= isCmd & (code == CMD_UNL);
         cmd.unt <= isCmd & (code == CMD_UNT);
         cmd.gtl <= isCmd & (code == CMD_GTL);
         cmd.sdc <= isCmd & (code == CMD_SDC);
         cmd.dcl <= isCmd & (code == CMD_DCL);
         cmd.get <= isCmd & (code == CMD_GET);
         cmd.llo <= isCmd & (code == CMD_LLO);
         cmd.spe <= isCmd & (code == CMD_SPE);
         cmd.spd <= isCmd & (code == CMD_SPD);
      end
   end
endmodule : grs_cmd_decode

// >>> hdl/grs_status_set.sv
// One status register set: condition, event and enable
module grs_status_set
   import grs_pkg::*;
#(
   parameter int W          = SET_W,
   parameter bit PRESET_CLR = 1'b1     // Preset clears this enable
)(
   input  wire logic         core_clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] cond,
   input  wire logic         wrEn,
   input  wire logic [W-1:0] wrData,
   input  wire logic         rdEvt,
   input  wire logic         clsCmd,
   input  wire logic         presetCmd,
   output      logic [W-1:0] evt,
   output      logic [W-1:0] en,
   output      logic         summary
);
   logic [W-1:0] condPrev_reg;   // Condition one cycle ago
   logic [W-1:0] evt_reg;        // Latched events
   logic [W-1:0] en_reg;         // Mask
   logic [W-1:0] evt_next;
   logic [W-1:0] en_next;
   logic [W-1:0] condRise;

   // Condition is live, no storage; only its rise is latched
   assign condRise = cond & ~condPrev_reg;
   // A rise in the clearing cycle survives, so no event is lost
   assign evt_next = ((rdEvt | clsCmd) ? W'(SET_RST) : evt_reg) | condRise;
   // Write carries any value, zero clears all; reading never touches it
   assign en_next  = wrEn ? wrData
                   : (presetCmd && PRESET_CLR) ? W'(SET_RST) : en_reg;

   // State update; power-up clears events and enables
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         condPrev_reg <= W'(SET_RST);
         evt_reg      <= W'(SET_RST);
         en_reg       <= W'(SET_RST);
      end else begin
         condPrev_reg <= cond;
         evt_reg      <= evt_next;
         en_reg       <= en_next;
      end
   end

   assign evt     = evt_reg;
   assign en      = en_reg;
   assign summary = |(evt_reg & en_reg);
endmodule : grs_status_set

// >>> sim/grs_ctl_model.sv
// Bus controller model: frames command bytes with ATN
module grs_ctl_model (
   input  wire logic       core_clk,
   output      logic [7:0] cmdByte,
   output      logic       cmdValid,
   output      logic       atnPin
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle bus at time zero
   initial begin
      cmdByte  = 8'h00;
      cmdValid = 1'b0;
      atnPin   = 1'b0;
   end
   // ATN leads the byte so the pin synchroniser sees it first
   task send(input logic [7:0] b);
      @(negedge core_clk) atnPin = 1'b1;
      repeat (3) @(negedge core_clk);
      cmdByte  = b;
      cmdValid = 1'b1;
      @(negedge core_clk) cmdValid = 1'b0;
      // Released byte lines never keep the old value
      cmdByte = ~b;
      atnPin  = 1'b0;
   endtask : send
endmodule : grs_ctl_model

// >>> sim/tb_top.sv
// Self-checking bench for the remote and status unit
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import grs_pkg::*;
   localparam logic [4:0] ADR = 5'h0A;   // Our primary address
   logic        core_clk, nrst, renPin, ifcPin, spollRead, localKeyPin, mavIn;
   logic        wrEn, rdEvt, rdEn, clsCmd, presetCmd, atnPin, cmdValid;
   logic        remoteIndicator, listenerIndicator, talkerIndicator, srqIndicator;
   logic        lockoutActive, devClearPulse, spollMode, srqOut;
   logic [2:0]  trigSrcBus, trigPulse, trgAcc, rdSel, wrSel;
   logic [7:0]  cmdByte, keyPins, keysOut, statusByte, spollByte;
   logic [15:0] operCond, rdData, wrData, stdCond, quesCond, measCond;
   int          bad_count, n_tests, clrCnt, trgCnt;
   grs_ctl_model i_ctl (.core_clk, .cmdByte, .cmdValid, .atnPin);
   grs_remote_status i_dut (.core_clk, .nrst, .cmdByte, .cmdValid, .atnPin, .renPin, .ifcPin,
      .spollRead, .myAddr(ADR), .localKeyPin, .keyPins, .keysOut, .remoteIndicator,
      .listenerIndicator, .talkerIndicator, .srqIndicator, .lockoutActive, .trigSrcBus,
      .trigPulse, .devClearPulse, .mavIn, .eavIn(mavIn), .stdCond, .operCond,
      .quesCond, .measCond, .rdSel, .rdEvt, .rdEn, .rdData, .wrSel,
      .wrEn, .wrData, .clsCmd, .presetCmd, .statusByte, .spollByte, .spollMode, .srqOut);
   // Clock, 10 ns period
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // One-cycle pulses are caught by counting, so a stuck pulse shows too
   // Counting waits for reset release, so unknown power-up outputs never reach the accumulator
   always @(posedge core_clk) begin
      if (nrst) begin
         clrCnt += int'(devClearPulse);
         trgCnt += int'(trigPulse != 3'h0);
         trgAcc |= trigPulse;
      end
   end
   task chk(input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         bad_count++;
         $display("Error at %0t: saw %h expected %h", $time, s, e);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask : cyc
   task send(input logic [7:0] b);
      i_ctl.send(b);
      cyc(3);
   endtask : send
   task wr(input logic [2:0] s, input logic [15:0] d);
      @(negedge core_clk) {wrSel, wrData, wrEn} = {s, d, 1'b1};
      @(negedge core_clk) wrEn = 1'b0;
   endtask : wr
   // Mode bit 1 reads and clears events, bit 0 reads the enable
   task rdchk(input logic [2:0] s, input logic [1:0] m, input logic [15:0] e);
      @(negedge core_clk) {rdSel, rdEvt, rdEn} = {s, m};
      @(negedge core_clk) rdEvt = 1'b0;
      chk(rdData, e);
   endtask : rdchk
   task close_out;
      $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : close_out
   // Watchdog in case a sequence hangs
   initial begin
      #400000;
      bad_count++;
      close_out();
   end
   // Main sequence
   initial begin
      {nrst, renPin, ifcPin, spollRead, localKeyPin, mavIn, wrEn, rdEvt, rdEn} = '0;
      {clsCmd, presetCmd, trigSrcBus, trgAcc, rdSel, wrSel, operCond, wrData, stdCond, quesCond, measCond} = '0;
      {bad_count, n_tests, clrCnt, trgCnt} = '0;
      keyPins = 8'hA5;
      cyc(10);
      nrst = 1'b1;
      cyc(4);
      chk({remoteIndicator, listenerIndicator, talkerIndicator, srqIndicator}, 16'h0000);
      rdchk(SEL_OPER, 2'h1, 16'h0000);
      chk(keysOut, 8'hA5);
      renPin = 1'b1;
      cyc(4);
      chk(remoteIndicator, 16'h0000);
      send({3'h1, ADR});
      chk({remoteIndicator, listenerIndicator, keysOut}, 10'h300);
      send({3'h2, ADR});
      chk({listenerIndicator, talkerIndicator}, 2'h1);
      send({3'h1, ADR});
      chk({listenerIndicator, talkerIndicator}, 2'h2);
      send({1'b0, CMD_UNL});
      send({3'h2, ADR});
      chk({listenerIndicator, talkerIndicator}, 2'h1);
      ifcPin = 1'b1;
      cyc(4);
      chk(talkerIndicator, 16'h0000);
      ifcPin = 1'b0;
      localKeyPin = 1'b1;
      cyc(6);
      chk({remoteIndicator, keysOut}, 9'h0A5);
      localKeyPin = 1'b0;
      send({3'h1, ADR});
      send({1'b0, CMD_LLO});
      localKeyPin = 1'b1;
      cyc(6);
      chk({remoteIndicator, lockoutActive}, 2'h3);
      localKeyPin = 1'b0;
      send({1'b0, CMD_GTL});
      cyc(3);
      chk({remoteIndicator, keysOut}, 9'h0A5);
      send({1'b0, CMD_UNL});
      send({1'b0, CMD_DCL});
      chk(16'(clrCnt), 16'h0001);
      send({1'b0, CMD_SDC});
      chk(16'(clrCnt), 16'h0001);
      send({3'h1, ADR});
      send({1'b0, CMD_SDC});
      chk(16'(clrCnt), 16'h0002);
      trigSrcBus = 3'h5;
      send({1'b0, CMD_GET});
      chk({trgAcc, 8'(trgCnt)}, 11'h501);
      wr(SEL_OPER, 16'h0010);
      wr(SEL_SRE, 16'h0080);
      operCond = 16'h0010;
      cyc(4);
      chk({statusByte, srqOut, srqIndicator}, 10'h303);
      rdchk(SEL_OPER, 2'h0, 16'h0010);
      operCond = 16'h0000;
      cyc(3);
      chk(statusByte, 8'hC0);
      rdchk(SEL_OPER, 2'h1, 16'h0010);
      rdchk(SEL_OPER, 2'h1, 16'h0010);
      send({1'b0, CMD_SPE});
      send({3'h2, ADR});
      chk({spollMode, spollByte}, 9'h1C0);
      @(negedge core_clk) spollRead = 1'b1;
      @(negedge core_clk) spollRead = 1'b0;
      cyc(4);
      chk({srqOut, srqIndicator, statusByte}, 10'h0C0);
      send({1'b0, CMD_SPD});
      rdchk(SEL_OPER, 2'h2, 16'h0010);
      cyc(3);
      chk(statusByte, 8'h00);
      send({1'b0, CMD_DCL});
      rdchk(SEL_OPER, 2'h1, 16'h0010);
      wr(SEL_STD, 16'hFFFF);
      @(negedge core_clk) presetCmd = 1'b1;
      @(negedge core_clk) presetCmd = 1'b0;
      rdchk(SEL_OPER, 2'h1, 16'h0000);
      rdchk(SEL_STD, 2'h1, 16'hFFFF);
      wr(SEL_STD, 16'h0000);
      rdchk(SEL_STD, 2'h1, 16'h0000);
      operCond = 16'h0010;
      cyc(2);
      @(negedge core_clk) clsCmd = 1'b1;
      @(negedge core_clk) clsCmd = 1'b0;
      rdchk(SEL_OPER, 2'h2, 16'h0000);
      // Remaining three sets and both queue flags reach their status byte bits
      wr(SEL_STD, 16'h0001);
      wr(SEL_QUES, 16'h0001);
      wr(SEL_MEAS, 16'h0001);
      {stdCond, quesCond, measCond, mavIn} = {16'h0001, 16'h0001, 16'h0001, 1'b1};
      cyc(4);
      chk(statusByte, 16'h003D);
      close_out();
   end
endmodule : tb_top
